// ---- logic/ulp_list_ptr_regs.sv ----
// Periodic and control list descriptor pointer bank of the host engine
//
// What this block does
// - Periodic pointer holds in-service descriptor address, bits 31..4; low bits zero.
// - Periodic pointer marks the head of a periodic list for this frame.
// - Control pointer holds in-service control descriptor address, bits 31..4; low zero.
// - After serving, control pointer advances; next frame resumes from saved place.
// - At list end, pending flag set: copy head into pointer, clear flag; a software set in that same cycle keeps the flag set.
// - Control pointer resets to zero; zero marks end of control list.
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module ulp_list_ptr_regs
    import ulp_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Periodic list walk from the engine
    input wire logic per_advance,
    input wire logic [31:0] per_next,
    // Control list walk from the engine
    input wire logic ctl_advance,
    input wire logic [31:0] ctl_next,
    input wire logic ctl_list_end,
    // Pointer state toward the engine
    output logic [31:0] periodic_pointer_field,
    output logic [31:0] control_pointer_field,
    output logic [31:0] control_queue_head,
    output logic ctrl_queue_pending_flag,
    output logic ctrl_queue_run_allow,
    output logic ctl_list_empty
);
    import ulp_pkg::*;

    ulp_bus_if bus ();

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    ulp_apb_decode u_dec (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .bus(bus)
    );

    // ----------------------------------------------------------------
    // Control list bookkeeping
    // ----------------------------------------------------------------
    wire wrap_now = ctl_list_end & ctrl_queue_pending_flag;
    wire ctl_hw_we = wrap_now | (ctl_advance & ~ctl_list_end);
    wire [31:0] ctl_hw_data = wrap_now ? control_queue_head : ctl_next;
    wire ctl_sw_we = bus.wr_ctl & ~ctrl_queue_run_allow;
    wire pending_set = bus.wr_cmd & bus.wdata[ULP_PENDING_BIT];
    logic next_pending;
    logic [31:0] next_head;

    // Software set wins over the clear at list end
    assign next_pending = pending_set ? 1'b1 : (wrap_now ? 1'b0 : ctrl_queue_pending_flag);
    assign next_head = bus.wdata & ULP_PTR_MASK;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_queue_pending_flag <= ULP_FLAG_RESET;
        end else begin
            ctrl_queue_pending_flag <= next_pending;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_queue_head <= ULP_PTR_RESET;
        end else if (bus.wr_head) begin
            control_queue_head <= next_head;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_queue_run_allow <= 1'b0;
        end else if (bus.wr_hctl) begin
            ctrl_queue_run_allow <= bus.wdata[ULP_RUN_ALLOW_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Pointer registers
    // ----------------------------------------------------------------
    // Periodic pointer is only ever loaded by the engine
    ulp_ptr_reg u_per (
        .pclk(pclk),
        .presetn(presetn),
        .hw_we(per_advance),
        .hw_data(per_next),
        .sw_we(1'b0),
        .sw_data(ULP_PTR_RESET),
        .q(periodic_pointer_field)
    );

    ulp_ptr_reg u_ctl (
        .pclk(pclk),
        .presetn(presetn),
        .hw_we(ctl_hw_we),
        .hw_data(ctl_hw_data),
        .sw_we(ctl_sw_we),
        .sw_data(bus.wdata),
        .q(control_pointer_field)
    );

    assign ctl_list_empty = (control_pointer_field == ULP_PTR_RESET);

    // ----------------------------------------------------------------
    // Read values
    // ----------------------------------------------------------------
    assign bus.per_val = periodic_pointer_field;
    assign bus.ctl_val = control_pointer_field;
    assign bus.head_val = control_queue_head;
    assign bus.cmd_val = 32'(ctrl_queue_pending_flag) << ULP_PENDING_BIT;
    assign bus.hctl_val = 32'(ctrl_queue_run_allow) << ULP_RUN_ALLOW_BIT;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_per_low_zero;
        periodic_pointer_field[ULP_PTR_LSB-1:0] == 4'h0;
    endproperty
    a_per_low_zero: assert property (p_per_low_zero) else $error("periodic pointer low bits not zero");

    property p_per_update;
        per_advance |=> periodic_pointer_field == ($past(per_next) & ULP_PTR_MASK);
    endproperty
    a_per_update: assert property (p_per_update) else $error("periodic pointer not rewritten");

    property p_per_hold;
        !per_advance |=> $stable(periodic_pointer_field);
    endproperty
    a_per_hold: assert property (p_per_hold) else $error("periodic pointer changed without engine");

    property p_ctl_low_zero;
        control_pointer_field[ULP_PTR_LSB-1:0] == 4'h0;
    endproperty
    a_ctl_low_zero: assert property (p_ctl_low_zero) else $error("control pointer low bits not zero");

    property p_ctl_advance;
        ctl_advance && !ctl_list_end |=> control_pointer_field == ($past(ctl_next) & ULP_PTR_MASK);
    endproperty
    a_ctl_advance: assert property (p_ctl_advance) else $error("control pointer did not advance");

    property p_ctl_wrap;
        ctl_list_end && ctrl_queue_pending_flag && !pending_set
            |=> control_pointer_field == $past(control_queue_head) && !ctrl_queue_pending_flag;
    endproperty
    a_ctl_wrap: assert property (p_ctl_wrap) else $error("control list wrap failed");

    property p_ctl_nowrap;
        ctl_list_end && !ctrl_queue_pending_flag && !ctl_sw_we |=> $stable(control_pointer_field);
    endproperty
    a_ctl_nowrap: assert property (p_ctl_nowrap) else $error("control pointer moved with flag clear");

    property p_ctl_sw_locked;
        bus.wr_ctl && ctrl_queue_run_allow && !ctl_advance && !ctl_list_end |=> $stable(control_pointer_field);
    endproperty
    a_ctl_sw_locked: assert property (p_ctl_sw_locked) else $error("control pointer written while running");

    property p_ctl_reset;
        $rose(presetn) |-> control_pointer_field == ULP_PTR_RESET && ctl_list_empty;
    endproperty
    a_ctl_reset: assert property (@(posedge pclk) p_ctl_reset) else $error("control pointer not zero after reset");

    property p_sw_write_discard;
        ctl_sw_we && !ctl_hw_we |=> control_pointer_field == {$past(bus.wdata[31:ULP_PTR_LSB]), 4'h0};
    endproperty
    a_sw_write_discard: assert property (p_sw_write_discard) else $error("control pointer write wrong");

    property p_pending_set;
        pending_set |=> ctrl_queue_pending_flag;
    endproperty
    a_pending_set: assert property (p_pending_set) else $error("pending flag set lost");

    // ----------------------------------------------------------------
    // Register and read path assertions
    // ----------------------------------------------------------------
    property p_ctl_hold;
        !ctl_advance && !ctl_list_end && !bus.wr_ctl |=> $stable(control_pointer_field);
    endproperty
    a_ctl_hold: assert property (p_ctl_hold) else $error("control pointer changed without a load");

    property p_ctl_to_empty;
        ctl_advance && !ctl_list_end && (ctl_next & ULP_PTR_MASK) == ULP_PTR_RESET |=> ctl_list_empty;
    endproperty
    a_ctl_to_empty: assert property (p_ctl_to_empty) else $error("zero link did not mark list end");

    property p_wrap_set_wins;
        ctl_list_end && ctrl_queue_pending_flag && pending_set
            |=> ctrl_queue_pending_flag && control_pointer_field == $past(control_queue_head);
    endproperty
    a_wrap_set_wins: assert property (p_wrap_set_wins) else $error("wrap with new set failed");

    property p_pending_hold;
        !pending_set && !wrap_now |=> $stable(ctrl_queue_pending_flag);
    endproperty
    a_pending_hold: assert property (p_pending_hold) else $error("pending flag changed on its own");

    property p_head_write;
        bus.wr_head |=> control_queue_head == ($past(bus.wdata) & ULP_PTR_MASK);
    endproperty
    a_head_write: assert property (p_head_write) else $error("control head write wrong");

    property p_head_hold;
        !bus.wr_head |=> $stable(control_queue_head);
    endproperty
    a_head_hold: assert property (p_head_hold) else $error("control head changed without write");

    property p_head_low_zero;
        control_queue_head[ULP_PTR_LSB-1:0] == 4'h0;
    endproperty
    a_head_low_zero: assert property (p_head_low_zero) else $error("control head low bits not zero");

    property p_run_allow_write;
        bus.wr_hctl |=> ctrl_queue_run_allow == $past(bus.wdata[ULP_RUN_ALLOW_BIT]);
    endproperty
    a_run_allow_write: assert property (p_run_allow_write) else $error("run allow write wrong");

    property p_run_allow_hold;
        !bus.wr_hctl |=> $stable(ctrl_queue_run_allow);
    endproperty
    a_run_allow_hold: assert property (p_run_allow_hold) else $error("run allow changed without write");

    property p_per_no_sw_write;
        psel && penable && pwrite && paddr == ULP_PERIODIC_PTR_ADDR && !per_advance
            |=> $stable(periodic_pointer_field);
    endproperty
    a_per_no_sw_write: assert property (p_per_no_sw_write) else $error("periodic pointer took a write");

    property p_per_no_err;
        psel && !penable && paddr == ULP_PERIODIC_PTR_ADDR |=> !pslverr;
    endproperty
    a_per_no_err: assert property (p_per_no_err) else $error("periodic pointer access gave error");

    property p_read_per;
        psel && !penable && !pwrite && paddr == ULP_PERIODIC_PTR_ADDR
            |=> prdata == $past(periodic_pointer_field);
    endproperty
    a_read_per: assert property (p_read_per) else $error("periodic pointer read wrong");

    property p_read_ctl;
        psel && !penable && !pwrite && paddr == ULP_CONTROL_PTR_ADDR |=> prdata == $past(control_pointer_field);
    endproperty
    a_read_ctl: assert property (p_read_ctl) else $error("control pointer read wrong");

    property p_read_head;
        psel && !penable && !pwrite && paddr == ULP_CONTROL_HEAD_ADDR |=> prdata == $past(control_queue_head);
    endproperty
    a_read_head: assert property (p_read_head) else $error("control head read wrong");

    property p_read_cmd;
        psel && !penable && !pwrite && paddr == ULP_CMD_STATUS_ADDR
            |=> prdata[ULP_PENDING_BIT] == $past(ctrl_queue_pending_flag);
    endproperty
    a_read_cmd: assert property (p_read_cmd) else $error("pending flag read wrong");

    property p_read_hctl;
        psel && !penable && !pwrite && paddr == ULP_HOST_CTRL_ADDR
            |=> prdata[ULP_RUN_ALLOW_BIT] == $past(ctrl_queue_run_allow);
    endproperty
    a_read_hctl: assert property (p_read_hctl) else $error("run allow read wrong");

    property p_read_low_zero;
        psel && !penable && !pwrite && (paddr == ULP_PERIODIC_PTR_ADDR || paddr == ULP_CONTROL_PTR_ADDR)
            |=> prdata[ULP_PTR_LSB-1:0] == 4'h0;
    endproperty
    a_read_low_zero: assert property (p_read_low_zero) else $error("pointer read low bits not zero");

    c_wrap: cover property (ctl_list_end && ctrl_queue_pending_flag);
    c_advance_twice: cover property (ctl_advance ##[1:8] ctl_advance);
    c_sw_write: cover property (ctl_sw_we);
    c_per_update: cover property (per_advance ##1 per_advance);
    c_sw_locked: cover property (bus.wr_ctl && ctrl_queue_run_allow);
endmodule
`default_nettype wire

// ---- logic/ulp_pkg.sv ----
// Package: register map, field positions and reset values of the list pointer bank
package ulp_pkg;
    // ----------------------------------------------------------------
    // Register byte addresses
    // ----------------------------------------------------------------
    localparam logic [31:0] ULP_PERIODIC_PTR_ADDR = 32'h3000_2c1c;
    localparam logic [31:0] ULP_CONTROL_PTR_ADDR = 32'h3000_2c20;
    localparam logic [31:0] ULP_CONTROL_HEAD_ADDR = 32'h3000_2c40;
    localparam logic [31:0] ULP_CMD_STATUS_ADDR = 32'h3000_2c44;
    localparam logic [31:0] ULP_HOST_CTRL_ADDR = 32'h3000_2c48;
    // ----------------------------------------------------------------
    // Field layout
    // ----------------------------------------------------------------
    localparam int ULP_PTR_LSB = 4;
    localparam logic [31:0] ULP_PTR_MASK = 32'hffff_fff0;
    localparam int ULP_PENDING_BIT = 1;
    localparam int ULP_RUN_ALLOW_BIT = 4;
    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [31:0] ULP_PTR_RESET = 32'h0000_0000;
    localparam logic ULP_FLAG_RESET = 1'b0;
    localparam logic [31:0] ULP_RDATA_RESET = 32'h0000_0000;
endpackage

// ---- logic/ulp_bus_if.sv ----
// Interface: write strobes and read values between the bus decoder and the pointer core
`timescale 1ns/1ps
`default_nettype none
interface ulp_bus_if;
    logic [31:0] wdata;
    logic wr_ctl;
    logic wr_head;
    logic wr_cmd;
    logic wr_hctl;
    logic [31:0] per_val;
    logic [31:0] ctl_val;
    logic [31:0] head_val;
    logic [31:0] cmd_val;
    logic [31:0] hctl_val;
    modport dec (output wdata, wr_ctl, wr_head, wr_cmd, wr_hctl,
                 input per_val, ctl_val, head_val, cmd_val, hctl_val);
    modport core (input wdata, wr_ctl, wr_head, wr_cmd, wr_hctl,
                  output per_val, ctl_val, head_val, cmd_val, hctl_val);
endinterface
`default_nettype wire

// ---- logic/ulp_ptr_reg.sv ----
// Descriptor pointer register: engine load over software load, low four bits held at zero
`timescale 1ns/1ps
`default_nettype none
module ulp_ptr_reg
    import ulp_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Loads
    input wire logic hw_we,
    input wire logic [31:0] hw_data,
    input wire logic sw_we,
    input wire logic [31:0] sw_data,
    // Value
    output logic [31:0] q
);
    logic [31:0] next_q;

    assign next_q = hw_we ? hw_data : sw_data;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= ULP_PTR_RESET;
        end else if (hw_we || sw_we) begin
            q <= next_q & ULP_PTR_MASK;
        end
    end
endmodule
`default_nettype wire

// ---- logic/ulp_apb_decode.sv ----
// APB slave: address decode, write strobes, registered read data and error answer
`timescale 1ns/1ps
`default_nettype none
module ulp_apb_decode
    import ulp_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Core side
    ulp_bus_if.dec bus
);
    wire hit_per = (paddr == ULP_PERIODIC_PTR_ADDR);
    wire hit_ctl = (paddr == ULP_CONTROL_PTR_ADDR);
    wire hit_head = (paddr == ULP_CONTROL_HEAD_ADDR);
    wire hit_cmd = (paddr == ULP_CMD_STATUS_ADDR);
    wire hit_hctl = (paddr == ULP_HOST_CTRL_ADDR);
    wire mapped = hit_per | hit_ctl | hit_head | hit_cmd | hit_hctl;
    wire setup = psel & ~penable;
    wire wr_access = psel & penable & pwrite;
    wire [31:0] rd_mux = hit_per ? bus.per_val :
                         hit_ctl ? bus.ctl_val :
                         hit_head ? bus.head_val :
                         hit_cmd ? bus.cmd_val :
                         hit_hctl ? bus.hctl_val : ULP_RDATA_RESET;

    // ----------------------------------------------------------------
    // Zero-wait answer; writes to the read-only pointer are dropped
    // ----------------------------------------------------------------
    assign pready = 1'b1;
    assign bus.wdata = pwdata;
    assign bus.wr_ctl = wr_access & hit_ctl;
    assign bus.wr_head = wr_access & hit_head;
    assign bus.wr_cmd = wr_access & hit_cmd;
    assign bus.wr_hctl = wr_access & hit_hctl;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= ULP_RDATA_RESET;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= pwrite ? ULP_RDATA_RESET : rd_mux;
            pslverr <= ~mapped;
        end
    end
endmodule
`default_nettype wire

// ---- sim/ulp_mem_model.sv ----
// Descriptor memory model: returns the link word of the descriptor now in service
`timescale 1ns/1ps
`default_nettype none
module ulp_mem_model (
    // Pointers in service
    input wire logic [31:0] cur_per,
    input wire logic [31:0] cur_ctl,
    // Link words read from memory
    output logic [31:0] per_next,
    output logic [31:0] ctl_next
);
    // Link words carry junk in the low nibble, as a careless memory image may
    assign per_next = cur_per + 32'h0000_0025;
    assign ctl_next = (cur_ctl == 32'h1234_5690) ? 32'h0000_0000 : cur_ctl + 32'h0000_0013;
endmodule
`default_nettype wire

// ---- sim/test_ulp_list_ptr_regs.sv ----
// Self-checking bench of the list pointer bank
`timescale 1ns/1ps
`default_nettype none
module test_ulp_list_ptr_regs;
    import ulp_pkg::*;
    // ----------------------------------------------------------------
    // Signals and design
    // ----------------------------------------------------------------
    logic pclk = 1'b0, presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000;
    logic [31:0] prdata, per_next, ctl_next, per_ptr, ctl_ptr, head;
    logic pready, pslverr, flag, run_allow, empty;
    logic per_advance = 1'b0, ctl_advance = 1'b0, ctl_list_end = 1'b0;
    int num_errors = 0, n_checks = 0;
    logic [31:0] rd, expv;
    logic er;
    typedef struct {logic [31:0] addr; logic [31:0] wdata; logic [31:0] exp; logic err;} ulp_row_s;
    ulp_row_s rows[4];
    ulp_list_ptr_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .per_advance(per_advance), .per_next(per_next), .ctl_advance(ctl_advance), .ctl_next(ctl_next),
        .ctl_list_end(ctl_list_end), .periodic_pointer_field(per_ptr), .control_pointer_field(ctl_ptr),
        .control_queue_head(head), .ctrl_queue_pending_flag(flag), .ctrl_queue_run_allow(run_allow),
        .ctl_list_empty(empty));
    ulp_mem_model u_mem (.cur_per(per_ptr), .cur_ctl(ctl_ptr), .per_next(per_next), .ctl_next(ctl_next));
    initial begin
        forever #4 pclk = ~pclk;
    end
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge pclk);
        penable <= 1'b1;
        rdata = 32'h0000_0000;
        err = 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                rdata = prdata;
                err = pslverr;
                break;
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task automatic pulse(input int which);
        @(posedge pclk);
        if (which == 0) per_advance <= 1'b1;
        if (which == 1) ctl_advance <= 1'b1;
        if (which == 2) ctl_list_end <= 1'b1;
        @(posedge pclk);
        per_advance <= 1'b0;
        ctl_advance <= 1'b0;
        ctl_list_end <= 1'b0;
        #1;
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #(8 * 3000);
        num_errors++;
        final_report();
    end
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        rows[0] = '{ULP_CONTROL_PTR_ADDR, 32'h1234_567f, 32'h1234_5670, 1'b0};
        rows[1] = '{ULP_PERIODIC_PTR_ADDR, 32'hdead_beef, 32'h0000_0000, 1'b0};
        rows[2] = '{ULP_CONTROL_HEAD_ADDR, 32'h2000_0008, 32'h2000_0000, 1'b0};
        rows[3] = '{32'h3000_2c00, 32'hffff_ffff, 32'h0000_0000, 1'b1};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        check("ctl ptr reset", ctl_ptr, ULP_PTR_RESET);
        check("list empty", {31'h0, empty}, 32'h0000_0001);
        apb(1'b0, ULP_PERIODIC_PTR_ADDR, 32'h0, rd, er);
        check("per ptr reset", rd, 32'h0000_0000);
        check("pready", {31'h0, pready}, 32'h0000_0001);
        $display("test reset done");
        foreach (rows[i]) begin
            apb(1'b1, rows[i].addr, rows[i].wdata, rd, er);
            check("write err", {31'h0, er}, {31'h0, rows[i].err});
            apb(1'b0, rows[i].addr, 32'h0, rd, er);
            check("read back", rd, rows[i].exp);
            check("read err", {31'h0, er}, {31'h0, rows[i].err});
        end
        check("head out", head, 32'h2000_0000);
        check("per ptr untouched", per_ptr, 32'h0000_0000);
        $display("test table done");
        expv = 32'h0000_0000;
        for (int i = 0; i < 2; i++) begin
            expv = (expv + 32'h0000_0025) & ULP_PTR_MASK;
            pulse(0);
            check("per advance", per_ptr, expv);
        end
        apb(1'b0, ULP_PERIODIC_PTR_ADDR, 32'h0, rd, er);
        check("per ptr read", rd, expv);
        $display("test periodic done");
        expv = 32'h1234_5670;
        for (int i = 0; i < 2; i++) begin
            expv = (expv + 32'h0000_0013) & ULP_PTR_MASK;
            pulse(1);
            check("ctl advance", ctl_ptr, expv);
        end
        pulse(1);
        check("ctl end zero", ctl_ptr, 32'h0000_0000);
        check("list empty end", {31'h0, empty}, 32'h0000_0001);
        $display("test control walk done");
        pulse(2);
        check("end no flag", ctl_ptr, 32'h0000_0000);
        apb(1'b1, ULP_CMD_STATUS_ADDR, 32'h0000_0002, rd, er);
        check("flag set", {31'h0, flag}, 32'h0000_0001);
        pulse(2);
        check("wrap to head", ctl_ptr, 32'h2000_0000);
        check("flag cleared", {31'h0, flag}, 32'h0000_0000);
        $display("test wrap done");
        apb(1'b1, ULP_HOST_CTRL_ADDR, 32'h0000_0010, rd, er);
        check("run allow", {31'h0, run_allow}, 32'h0000_0001);
        apb(1'b1, ULP_CONTROL_PTR_ADDR, 32'h5555_5550, rd, er);
        apb(1'b0, ULP_CONTROL_PTR_ADDR, 32'h0, rd, er);
        check("write while enabled", rd, 32'h2000_0000);
        pulse(1);
        check("advance enabled", ctl_ptr, 32'h2000_0010);
        $display("test enable done");
        @(posedge pclk);
        presetn <= 1'b0;
        #1;
        check("per ptr mid reset", per_ptr, ULP_PTR_RESET);
        check("ctl ptr mid reset", ctl_ptr, ULP_PTR_RESET);
        check("empty mid reset", {31'h0, empty}, 32'h0000_0001);
        check("run allow mid reset", {31'h0, run_allow}, 32'h0000_0000);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        apb(1'b0, ULP_CONTROL_PTR_ADDR, 32'h0, rd, er);
        check("ctl read after reset", rd, ULP_PTR_RESET);
        $display("test mid reset done");
        final_report();
    end
endmodule
`default_nettype wire
